// ===== logic/tec_top.sv
// Function
// RULE1: second unit clock codes, /16 and /4096 taps
// RULE2: first unit same, but /4 and /8192
// RULE3: software stops timer before changing clock select
// RULE4: software writes zero to clock select bits 7:3
// RULE5: run bit low clears and holds counter
// RULE6: mode bit picks clear-on-match or pwm
// RULE7: preset pair: 01 clears flop, 10 sets
// RULE8: preset bits read back as zero
// RULE9: presets act only outside pwm mode
// RULE10: bit 1: inversion enable, or pwm active level
// RULE11: output enable low forces output low
// RULE12: software configures mode in four ordered writes
// RULE13: software stops counter before changing mode bit
// RULE14: stopping pwm makes output inactive
// RULE15: mode bits reach the pin immediately
// RULE16: reset clears mode and clock select registers
// RULE17: software keeps second unit mode bit low
// RULE18: software sets pin direction and latch per use
// RULE19: direction 0 drives, 1 floats; reset FFH
// RULE20: interval match clears counter and requests interrupt
// RULE21: counter steps on count tick, reset clears
// RULE22: compare match requests, pwm match goes inactive
// RULE23: event pin synchronised, edge becomes one pulse
// RULE24: divided clocks are prescaler enable pulses
//
// Added by the designer: the APB interface to the registers.
module tec_top #(
    parameter int unsigned ADDR_W = tec_pkg::ADDR_W
) (
    // clock, reset, enable
    input  wire logic              CLK_IN,
    input  wire logic              RST_N_IN,
    input  wire logic              CE_IN,
    // apb slave
    input  wire logic              PSEL_IN,
    input  wire logic              PENABLE_IN,
    input  wire logic              PWRITE_IN,
    input  wire logic [ADDR_W-1:0] PADDR_IN,
    input  wire logic [31:0]       PWDATA_IN,
    output logic [31:0]            PRDATA_OUT,
    output logic                   PREADY_OUT,
    output logic                   PSLVERR_OUT,
    // shared timer pin of unit a
    input  wire logic              TIMER_PIN_A_IN,
    output logic                   TIMER_PIN_A_OUT,
    output logic                   TIMER_PIN_A_OE_OUT,
    // shared timer pin of unit b
    input  wire logic              TIMER_PIN_B_IN,
    output logic                   TIMER_PIN_B_OUT,
    output logic                   TIMER_PIN_B_OE_OUT,
    // compare match requests
    output logic                   COMPARE_MATCH_IRQ_A_OUT,
    output logic                   COMPARE_MATCH_IRQ_B_OUT,
    // direction of all port 1 and port 3 pins, timer pin bits included
    output logic [7:0]             PORT1_DIRECTION_OUT,
    output logic [7:0]             PORT3_DIRECTION_OUT
);
    localparam int unsigned UNITS = 2;

    // per-unit signals, index 0 is unit a, then the shared port, bus and prescaler signals
    tec_pkg::tec_mode_t   mode_reg     [UNITS];
    logic [2:0]           clk_sel_reg  [UNITS];
    logic [7:0]           cmp_reg      [UNITS];
    tec_pkg::tec_preset_t preset       [UNITS];
    logic [7:0]           count        [UNITS];
    logic                 irq          [UNITS];
    logic                 tout         [UNITS];
    logic                 tick         [UNITS];
    logic                 ev_s1_reg    [UNITS];
    logic                 ev_s2_reg    [UNITS];
    logic                 ev_s3_reg    [UNITS];
    logic                 ev_rise      [UNITS];
    logic                 ev_fall      [UNITS];
    logic [7:0]           port1_dir_reg;
    logic [7:0]           port3_dir_reg;
    logic [7:0]           rd_mux;
    logic [31:0]          prdata_reg;
    logic [tec_pkg::PRE_W:0] taps;

    // apb decode on the word index
    wire logic [tec_pkg::IDX_W-1:0] idx = PADDR_IN[ADDR_W-1:2];
    wire logic hit_p1     = idx == tec_pkg::IDX_PORT1_DIR;
    wire logic hit_p3     = idx == tec_pkg::IDX_PORT3_DIR;
    wire logic hit_mode_a = idx == tec_pkg::IDX_TIMER_A_MODE;
    wire logic hit_mode_b = idx == tec_pkg::IDX_TIMER_B_MODE;
    wire logic hit_clk_a  = idx == tec_pkg::IDX_TIMER_A_CLK;
    wire logic hit_clk_b  = idx == tec_pkg::IDX_TIMER_B_CLK;
    wire logic hit_cmp_a  = idx == tec_pkg::IDX_TIMER_A_CMP;
    wire logic hit_cmp_b  = idx == tec_pkg::IDX_TIMER_B_CMP;
    wire logic hit_cnt_a  = idx == tec_pkg::IDX_TIMER_A_CNT;
    wire logic hit_cnt_b  = idx == tec_pkg::IDX_TIMER_B_CNT;
    wire logic mapped     = hit_p1 | hit_p3 | hit_mode_a | hit_mode_b | hit_clk_a
                          | hit_clk_b | hit_cmp_a | hit_cmp_b | hit_cnt_a | hit_cnt_b;
    wire logic setup      = PSEL_IN & ~PENABLE_IN;
    wire logic access     = PSEL_IN & PENABLE_IN & CE_IN;
    wire logic wr         = access & PWRITE_IN & mapped;
    wire logic [UNITS-1:0] wr_mode = {wr & hit_mode_b, wr & hit_mode_a};
    wire logic [UNITS-1:0] wr_clk  = {wr & hit_clk_b, wr & hit_clk_a};
    wire logic [UNITS-1:0] wr_cmp  = {wr & hit_cmp_b, wr & hit_cmp_a};
    wire logic [7:0] wdata = PWDATA_IN[7:0];

    // a frozen block stalls the bus rather than dropping the access
    assign PREADY_OUT  = CE_IN;
    assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;
    assign PRDATA_OUT  = prdata_reg;

    // read view: preset bits are never stored, so they read zero
    function automatic logic [7:0] mode_view(input tec_pkg::tec_mode_t m);
        mode_view = {m.run, m.pwm, 4'h0, m.level, m.oe}; // see RULE8
    endfunction

    assign rd_mux = hit_p1     ? port1_dir_reg :
                    hit_p3     ? port3_dir_reg :
                    hit_mode_a ? mode_view(mode_reg[0]) :
                    hit_mode_b ? mode_view(mode_reg[1]) :
                    hit_clk_a  ? {5'h00, clk_sel_reg[0]} :
                    hit_clk_b  ? {5'h00, clk_sel_reg[1]} :
                    hit_cmp_a  ? cmp_reg[0] :
                    hit_cmp_b  ? cmp_reg[1] :
                    hit_cnt_a  ? count[0] :
                    hit_cnt_b  ? count[1] : 8'h00;

    // read data captured in the setup cycle, valid through access
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            prdata_reg <= 32'h0000_0000;
        end else if (CE_IN && setup) begin
            prdata_reg <= {24'h00_0000, rd_mux};
        end
    end

    // port direction registers; port 3 upper bits are fixed high
    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            port1_dir_reg <= tec_pkg::DIR_RST; // see RULE19
            port3_dir_reg <= tec_pkg::DIR_RST; // see RULE19
        end else if (wr && hit_p1) begin
            port1_dir_reg <= wdata;
        end else if (wr && hit_p3) begin
            port3_dir_reg <= wdata | tec_pkg::PORT3_HIGH;
        end
    end

    // count clock selection per unit
    function automatic logic pick_tick(input logic [2:0] sel, input logic unit_b,
                                       input logic fall, input logic rise,
                                       input logic [tec_pkg::PRE_W:0] t);
        logic r;
        r = 1'b0;
        unique case (tec_pkg::tec_clk_sel_t'(sel))
            tec_pkg::CS_FALL: r = fall;
            tec_pkg::CS_RISE: r = rise;
            tec_pkg::CS_PCLK: r = t[tec_pkg::DIV_1];
            tec_pkg::CS_DIV1: r = t[tec_pkg::DIV_2];
            tec_pkg::CS_DIV2: r = unit_b ? t[tec_pkg::DIV_B4]  // see RULE1
                                         : t[tec_pkg::DIV_A4]; // see RULE2
            tec_pkg::CS_DIV3: r = t[tec_pkg::DIV_5];
            tec_pkg::CS_DIV4: r = t[tec_pkg::DIV_6];
            tec_pkg::CS_DIV5: r = unit_b ? t[tec_pkg::DIV_B7]  // see RULE1
                                         : t[tec_pkg::DIV_A7]; // see RULE2
        endcase
        pick_tick = r;
    endfunction

    // shared divider for both units
    tec_prescaler #(
        .WIDTH    (tec_pkg::PRE_W)
    ) u_prescaler (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .tick_out (taps)
    );

    // pin levels seen by the event inputs
    wire logic [UNITS-1:0] pin_in = {TIMER_PIN_B_IN, TIMER_PIN_A_IN};

    for (genvar u = 0; u < UNITS; u++) begin : g_unit
        // mode, clock select and compare registers
        always_ff @(posedge CLK_IN) begin
            if (!RST_N_IN) begin
                mode_reg[u]    <= tec_pkg::tec_mode_t'(4'h0); // see RULE16
                clk_sel_reg[u] <= tec_pkg::CLK_RST;           // see RULE16
                cmp_reg[u]     <= tec_pkg::CMP_RST;
            end else begin
                if (wr_mode[u]) begin
                    mode_reg[u] <= {wdata[tec_pkg::BIT_RUN], wdata[tec_pkg::BIT_PWM],
                                    wdata[tec_pkg::BIT_LEVEL], wdata[tec_pkg::BIT_OE]};
                end
                if (wr_clk[u]) begin
                    clk_sel_reg[u] <= wdata[2:0];
                end
                if (wr_cmp[u]) begin
                    cmp_reg[u] <= wdata;
                end
            end
        end

        // preset pulses; the forbidden 11 does nothing
        assign preset[u].set = wr_mode[u] & wdata[tec_pkg::BIT_PSET]
                             & ~wdata[tec_pkg::BIT_PCLR]; // see RULE7
        assign preset[u].clr = wr_mode[u] & wdata[tec_pkg::BIT_PCLR]
                             & ~wdata[tec_pkg::BIT_PSET]; // see RULE7

        // event pin: two-flop synchroniser, third flop for the edge
        always_ff @(posedge CLK_IN) begin
            if (!RST_N_IN) begin
                ev_s1_reg[u] <= 1'b0;
                ev_s2_reg[u] <= 1'b0;
                ev_s3_reg[u] <= 1'b0;
            end else if (CE_IN) begin
                ev_s1_reg[u] <= pin_in[u];    // see RULE23
                ev_s2_reg[u] <= ev_s1_reg[u];
                ev_s3_reg[u] <= ev_s2_reg[u];
            end
        end

        // edges become one-cycle count pulses
        assign ev_rise[u] = ev_s2_reg[u] & ~ev_s3_reg[u]; // see RULE23
        assign ev_fall[u] = ev_s3_reg[u] & ~ev_s2_reg[u]; // see RULE23
        assign tick[u]    = pick_tick(clk_sel_reg[u], u == 1, ev_fall[u],
                                      ev_rise[u], taps);

        tec_unit u_unit (
            .clk_in    (CLK_IN),
            .rst_n_in  (RST_N_IN),
            .ce_in     (CE_IN),
            .mode_in   (mode_reg[u]),
            .preset_in (preset[u]),
            .tick_in   (tick[u]),
            .cmp_in    (cmp_reg[u]),
            .count_out (count[u]),
            .irq_out   (irq[u]),
            .tout_out  (tout[u])
        );

        chk_edge_single: assert property ( // see RULE23
            @(posedge CLK_IN) disable iff (!RST_N_IN)
            CE_IN && (ev_rise[u] || ev_fall[u]) |=> !(ev_rise[u] || ev_fall[u]))
            else $error("event edge longer than one cycle");
    end

    // pins: direction bit 0 turns the driver on
    assign TIMER_PIN_A_OUT    = tout[0];
    assign TIMER_PIN_B_OUT    = tout[1];
    assign TIMER_PIN_A_OE_OUT = ~port1_dir_reg[tec_pkg::PIN_A_BIT]; // see RULE19
    assign TIMER_PIN_B_OE_OUT = ~port3_dir_reg[tec_pkg::PIN_B_BIT]; // see RULE19
    assign COMPARE_MATCH_IRQ_A_OUT = irq[0];
    assign COMPARE_MATCH_IRQ_B_OUT = irq[1];
    assign PORT1_DIRECTION_OUT = port1_dir_reg;
    assign PORT3_DIRECTION_OUT = port3_dir_reg;

    // checks
    chk_preset_read_zero: assert property ( // see RULE8
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && setup && (hit_mode_a || hit_mode_b) |=> PRDATA_OUT[3:2] == 2'b00)
        else $error("preset bits read nonzero");
    chk_reset_regs: assert property ( // see RULE16
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !$past(RST_N_IN) |-> mode_view(mode_reg[0]) == 8'h00
            && mode_view(mode_reg[1]) == 8'h00
            && clk_sel_reg[0] == 3'h0 && clk_sel_reg[1] == 3'h0)
        else $error("mode or clock select not cleared by reset");
    chk_dir_reset: assert property ( // see RULE19
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        !$past(RST_N_IN) |-> !TIMER_PIN_A_OE_OUT && !TIMER_PIN_B_OE_OUT
            && PORT1_DIRECTION_OUT == 8'hFF)
        else $error("pin driver on after reset");
    chk_ext_count: assert property ( // see RULE1
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        CE_IN && clk_sel_reg[1] == 3'h1 && mode_reg[1].run && !ev_rise[1]
        && count[1] != cmp_reg[1] |=> count[1] == $past(count[1]))
        else $error("unit b counted without an event edge");

    cov_mode_write: cover property (@(posedge CLK_IN) wr_mode[0] ##1 mode_reg[0].run);
endmodule // tec_top

// ===== logic/tec_pkg.sv
package tec_pkg;
    // apb address width; a register index sits in bits 17:2
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned IDX_W  = 16;

    // register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_PORT1_DIR    = 16'hFF21;
    localparam logic [IDX_W-1:0] IDX_PORT3_DIR    = 16'hFF23;
    localparam logic [IDX_W-1:0] IDX_TIMER_B_MODE = 16'hFF43;
    localparam logic [IDX_W-1:0] IDX_TIMER_A_CLK  = 16'hFF6A;
    localparam logic [IDX_W-1:0] IDX_TIMER_A_MODE = 16'hFF6B;
    localparam logic [IDX_W-1:0] IDX_TIMER_A_CMP  = 16'hFF70;
    localparam logic [IDX_W-1:0] IDX_TIMER_B_CMP  = 16'hFF71;
    localparam logic [IDX_W-1:0] IDX_TIMER_A_CNT  = 16'hFF72;
    localparam logic [IDX_W-1:0] IDX_TIMER_B_CNT  = 16'hFF73;
    localparam logic [IDX_W-1:0] IDX_TIMER_B_CLK  = 16'hFF8C;

    // values after reset, and the port 3 fixed-high mask
    localparam logic [7:0] MODE_RST   = 8'h00;
    localparam logic [2:0] CLK_RST    = 3'h0;
    localparam logic [7:0] DIR_RST    = 8'hFF;
    localparam logic [7:0] CNT_RST    = 8'h00;
    localparam logic [7:0] CMP_RST    = 8'h00;
    localparam logic [7:0] PORT3_HIGH = 8'hF0;

    // mode register field positions
    localparam int unsigned BIT_RUN   = 7;
    localparam int unsigned BIT_PWM   = 6;
    localparam int unsigned BIT_PSET  = 3;
    localparam int unsigned BIT_PCLR  = 2;
    localparam int unsigned BIT_LEVEL = 1;
    localparam int unsigned BIT_OE    = 0;

    // direction bit of each shared timer pin
    localparam int unsigned PIN_A_BIT = 7;
    localparam int unsigned PIN_B_BIT = 3;

    // prescaler length and divider tap positions
    localparam int unsigned PRE_W   = 13;
    localparam int unsigned DIV_1   = 0;
    localparam int unsigned DIV_2   = 1;
    localparam int unsigned DIV_A4  = 2;
    localparam int unsigned DIV_B4  = 4;
    localparam int unsigned DIV_5   = 6;
    localparam int unsigned DIV_6   = 8;
    localparam int unsigned DIV_A7  = 13;
    localparam int unsigned DIV_B7  = 12;

    // count clock select codes
    typedef enum logic [2:0] {
        CS_FALL = 3'h0,
        CS_RISE = 3'h1,
        CS_PCLK = 3'h2,
        CS_DIV1 = 3'h3,
        CS_DIV2 = 3'h4,
        CS_DIV3 = 3'h5,
        CS_DIV4 = 3'h6,
        CS_DIV5 = 3'h7
    } tec_clk_sel_t;

    // stored mode bits of one unit
    typedef struct packed {
        logic run;
        logic pwm;
        logic level;
        logic oe;
    } tec_mode_t;

    // one-cycle preset requests from a mode write
    typedef struct packed {
        logic set;
        logic clr;
    } tec_preset_t;
endpackage

// ===== logic/tec_prescaler.sv
module tec_prescaler #(
    parameter int unsigned WIDTH = tec_pkg::PRE_W
) (
    // clock, reset, enable
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    // tap k pulses once every 2^k cycles
    output logic [WIDTH:0]        tick_out
);
    logic [WIDTH-1:0] cnt_reg;

    // free-running divider, never gated by a timer's run bit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
        end else if (ce_in) begin
            cnt_reg <= cnt_reg + 1'b1; // see RULE24
        end
    end

    // enables, not clocks: no gated clock reaches the counters
    assign tick_out[0] = 1'b1;
    for (genvar k = 1; k <= WIDTH; k++) begin : g_tap
        assign tick_out[k] = &cnt_reg[k-1:0]; // see RULE24
    end
endmodule // tec_prescaler

// ===== logic/tec_unit.sv
module tec_unit (
    // clock, reset, enable
    input  wire logic               clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               ce_in,
    // settings and count enable
    input  wire tec_pkg::tec_mode_t   mode_in,
    input  wire tec_pkg::tec_preset_t preset_in,
    input  wire logic               tick_in,
    input  wire logic [7:0]         cmp_in,
    // state and output
    output logic [7:0]              count_out,
    output logic                    irq_out,
    output logic                    tout_out
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] cmp_act_reg;
    logic       tff_reg;
    logic       pwm_ff_reg;
    logic       irq_reg;

    // counter stepping and compare decode
    wire logic       step      = mode_in.run & tick_in; // see RULE21
    wire logic       wrap      = count_reg == 8'hFF;
    wire logic [7:0] count_inc = count_reg + 8'h01;
    wire logic       clr_match = step & ~mode_in.pwm & (count_reg == cmp_in); // see RULE20
    // pwm takes a new compare only at overflow, so a rewrite never cuts a pulse
    wire logic [7:0] cmp_use   = wrap ? cmp_in : cmp_act_reg;
    wire logic       pwm_hit   = count_inc == cmp_use;
    wire logic       no_pset   = ~(preset_in.set | preset_in.clr);

    assign count_next = !mode_in.run ? tec_pkg::CNT_RST :  // see RULE5
                        !tick_in     ? count_reg :
                        clr_match    ? tec_pkg::CNT_RST :  // see RULE6
                                       count_inc;

    // counter and compare-match request
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_reg <= tec_pkg::CNT_RST; // see RULE21
            irq_reg   <= 1'b0;
        end else if (ce_in) begin
            count_reg <= count_next;
            irq_reg   <= clr_match; // see RULE22
        end
    end

    // pwm compare copy and pwm flop
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cmp_act_reg <= tec_pkg::CMP_RST;
            pwm_ff_reg  <= 1'b0;
        end else if (ce_in) begin
            if (!mode_in.pwm || !mode_in.run || (step && wrap)) begin
                cmp_act_reg <= cmp_in;
            end
            if (!mode_in.run || !mode_in.pwm) begin
                pwm_ff_reg <= 1'b0; // see RULE14
            end else if (step) begin
                pwm_ff_reg <= pwm_hit ? 1'b0 : (wrap ? 1'b1 : pwm_ff_reg); // see RULE22
            end
        end
    end

    // timer flop: preset from software beats inversion on match
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tff_reg <= 1'b0;
        end else if (ce_in) begin
            if (!mode_in.pwm && preset_in.set) begin
                tff_reg <= 1'b1; // see RULE7 see RULE9
            end else if (!mode_in.pwm && preset_in.clr) begin
                tff_reg <= 1'b0; // see RULE7 see RULE9
            end else if (clr_match && mode_in.level) begin
                tff_reg <= ~tff_reg; // see RULE10
            end
        end
    end

    // pin level follows the settings at once, run or not
    assign tout_out  = mode_in.oe & (mode_in.pwm ? (pwm_ff_reg ^ mode_in.level)
                                                 : tff_reg); // see RULE10 see RULE11 see RULE15
    assign count_out = count_reg;
    assign irq_out   = irq_reg;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_stop_clears: assert property ( // see RULE5
        ce_in && !mode_in.run |=> count_reg == 8'h00)
        else $error("stopped counter not cleared");
    chk_match_restart: assert property ( // see RULE20
        ce_in && clr_match |=> count_reg == 8'h00 && irq_out)
        else $error("match did not clear and request");
    chk_step_advance: assert property ( // see RULE21
        ce_in && step && !clr_match |=> count_reg == $past(count_inc))
        else $error("counter did not advance on tick");
    chk_pwm_no_irq: assert property ( // see RULE22
        mode_in.pwm && $past(mode_in.pwm) |-> !irq_out)
        else $error("request raised in pwm mode");
    chk_pwm_stop_idle: assert property ( // see RULE14
        ce_in && mode_in.pwm && !mode_in.run ##1 mode_in.pwm
        |-> tout_out == (mode_in.oe & mode_in.level))
        else $error("stopped pwm output not inactive");
    chk_preset_low: assert property ( // see RULE7
        ce_in && preset_in.clr && !preset_in.set && !mode_in.pwm |=> !tff_reg)
        else $error("preset low not applied");
    chk_preset_pwm_ignored: assert property ( // see RULE9
        ce_in && mode_in.pwm |=> tff_reg == $past(tff_reg))
        else $error("timer flop moved in pwm mode");
    chk_invert_match: assert property ( // see RULE10
        ce_in && clr_match && mode_in.level && no_pset |=> tff_reg != $past(tff_reg))
        else $error("timer flop not inverted on match");
    chk_oe_low: assert property ( // see RULE11
        !mode_in.oe |-> !tout_out)
        else $error("disabled output not low");

    cov_match: cover property (ce_in && clr_match ##1 irq_out);
    cov_pwm_wrap: cover property (ce_in && step && wrap && mode_in.pwm);
endmodule // tec_unit

// ===== verification/tec_pin_model.sv
// far side of the two timer pins: event source on pin b when its driver is off
module tec_pin_model (
    // clock
    input  wire logic clk_in,
    // device side of each pin
    input  wire logic a_oe_in,
    input  wire logic a_drv_in,
    input  wire logic b_oe_in,
    input  wire logic b_drv_in,
    // resolved pin levels
    output logic      a_pin_out,
    output logic      b_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lvl = 1'b0;
    // device driver wins while enabled, else pin a reads low and the event source drives pin b
    assign a_pin_out = a_oe_in ? a_drv_in : 1'b0;
    assign b_pin_out = b_oe_in ? b_drv_in : lvl;
    // each level held 4 cycles so the synchroniser cannot miss it
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_in);
            lvl <= 1'b1;
            repeat (4) @(posedge clk_in);
            lvl <= 1'b0;
        end
        repeat (4) @(posedge clk_in);
    endtask
endmodule // tec_pin_model

// ===== verification/tec_top_bench.sv
module tec_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, rst_n_in, psel, penable, pwrite, pready, pslverr, err;
    logic        pa_out, pa_oe, pb_out, pb_oe, pa_in, pb_in, irq_a, irq_b;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  p1_dir, p3_dir;
    int          miscompares, total_checks, cycles;
    // 250 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    tec_top tec_top_i (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .CE_IN(1'b1),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .TIMER_PIN_A_IN(pa_in), .TIMER_PIN_A_OUT(pa_out),
        .TIMER_PIN_A_OE_OUT(pa_oe), .TIMER_PIN_B_IN(pb_in), .TIMER_PIN_B_OUT(pb_out),
        .TIMER_PIN_B_OE_OUT(pb_oe), .COMPARE_MATCH_IRQ_A_OUT(irq_a),
        .COMPARE_MATCH_IRQ_B_OUT(irq_b), .PORT1_DIRECTION_OUT(p1_dir),
        .PORT3_DIRECTION_OUT(p3_dir));
    tec_pin_model tec_pin_model_i (.clk_in(clk_in), .a_oe_in(pa_oe), .a_drv_in(pa_out),
        .b_oe_in(pb_oe), .b_drv_in(pb_out), .a_pin_out(pa_in), .b_pin_out(pb_in));
    task automatic wrap_up;
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // hang guard, runs need well under 20000 cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // apb transfer: setup, access held until pready sampled high
    task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d);
        @(posedge clk_in);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= {i, 2'b00}; pwdata <= {24'h000000, d};
        @(posedge clk_in);
        penable <= 1'b1;
        @(posedge clk_in);
        while (pready !== 1'b1) @(posedge clk_in);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        xfer(1'b1, i, d);
    endtask
    task automatic rdc(input logic [15:0] i, input logic [7:0] e);
        xfer(1'b0, i, 8'h00);
        chk(rd, {24'h000000, e});
    endtask
    // interval period between two match requests, then stop clears count
    task automatic period(input logic b, input logic [7:0] cs, cmp, input int e);
        logic [15:0] mi;
        int n;
        mi = b ? tec_pkg::IDX_TIMER_B_MODE : tec_pkg::IDX_TIMER_A_MODE;
        wr(mi, 8'h00);
        wr(b ? tec_pkg::IDX_TIMER_B_CLK : tec_pkg::IDX_TIMER_A_CLK, cs);
        wr(b ? tec_pkg::IDX_TIMER_B_CMP : tec_pkg::IDX_TIMER_A_CMP, cmp);
        wr(mi, 8'h80);
        n = 0;
        do begin @(posedge clk_in); n++; end while ((b ? irq_b : irq_a) !== 1'b1 && n < 500);
        n = 0;
        do begin @(posedge clk_in); n++; end while ((b ? irq_b : irq_a) !== 1'b1 && n < 500);
        chk(n, e);
        wr(mi, 8'h00);
        rdc(b ? tec_pkg::IDX_TIMER_B_CNT : tec_pkg::IDX_TIMER_A_CNT, 8'h00);
    endtask
    // main sequence
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; rst_n_in = 0;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rdc(tec_pkg::IDX_TIMER_A_MODE, 8'h00);
        rdc(tec_pkg::IDX_TIMER_B_MODE, 8'h00);
        rdc(tec_pkg::IDX_TIMER_A_CLK, 8'h00);
        rdc(tec_pkg::IDX_TIMER_B_CLK, 8'h00);
        rdc(tec_pkg::IDX_PORT1_DIR, 8'hFF);
        rdc(tec_pkg::IDX_PORT3_DIR, 8'hFF);
        chk(pa_oe, 1'b0);
        chk(pb_oe, 1'b0);
        chk(p1_dir, 8'hFF);
        chk(p3_dir, 8'hFF);
        // unmapped index refused, write ignored
        wr(16'h0001, 8'h5A);
        chk(err, 1'b1);
        rdc(16'h0001, 8'h00);
        chk(err, 1'b1);
        wr(tec_pkg::IDX_TIMER_A_CLK, 8'h02);
        rdc(tec_pkg::IDX_TIMER_A_CLK, 8'h02);
        period(1'b0, 8'h02, 8'h03, 4);
        period(1'b0, 8'h04, 8'h01, 8);
        period(1'b1, 8'h04, 8'h01, 32);
        // event counting on pin b, both edge codes
        for (int c = 0; c < 2; c++) begin
            wr(tec_pkg::IDX_TIMER_B_MODE, 8'h00);
            wr(tec_pkg::IDX_TIMER_B_CLK, c[7:0]);
            wr(tec_pkg::IDX_TIMER_B_CMP, 8'hFF);
            wr(tec_pkg::IDX_TIMER_B_MODE, 8'h80);
            tec_pin_model_i.pulse(5);
            rdc(tec_pkg::IDX_TIMER_B_CNT, 8'h05);
        end
        // output flop presets and enable on pin a, stopped counter
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h00);
        wr(tec_pkg::IDX_PORT1_DIR, 8'h7F);
        @(posedge clk_in);
        chk(pa_oe, 1'b1);
        chk(p1_dir, 8'h7F);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h01);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h09);
        @(posedge clk_in);
        chk(pa_out, 1'b1);
        rdc(tec_pkg::IDX_TIMER_A_MODE, 8'h01);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h05);
        @(posedge clk_in);
        chk(pa_out, 1'b0);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h09);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h08);
        @(posedge clk_in);
        chk(pa_out, 1'b0);
        // pwm stopped: inactive level follows bit 1, presets ignored
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h42);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h43);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h47);
        @(posedge clk_in);
        chk(pa_out, 1'b1);
        wr(tec_pkg::IDX_TIMER_A_MODE, 8'h41);
        @(posedge clk_in);
        chk(pa_out, 1'b0);
        wrap_up();
    end
endmodule // tec_top_bench
